// *** hw/slc_ram_guard.sv ***
// Secure RAM segment access gate
`timescale 1ns/1ps
module slc_ram_guard
(
	input  wire logic        bsr_en_i,    // Boot secure RAM protection on
	input  wire logic        ssr_en_i,    // Segment secure RAM protection on
	input  wire logic        in_bsr_i,    // Address lies in boot secure RAM
	input  wire logic        in_ssr_i,    // Address lies in segment secure RAM
	input  wire logic        exec_boot_i, // Code runs from boot flash segment
	input  wire logic        exec_sec_i,  // Code runs from secure flash segment
	output logic             blocked_o    // Access must be suppressed
);
	// Each protected window only opens for its own flash segment
	always_comb
	begin
		blocked_o = (bsr_en_i && in_bsr_i && !exec_boot_i) // RL11
			|| (ssr_en_i && in_ssr_i && !exec_sec_i);     // RL12
	end
endmodule // slc_ram_guard

// *** hw/slc_stack_limit_checker.sv ***
// Stack pointer, stack limit checking and secure RAM gating
//
// How it works
// RL1 - Working register fifteen is the stack pointer, addressing next free word, growing up.
// RL2 - Pop decrements before reading; push increments after writing.
// RL3 - Call pushes program counter with its top bit forced clear.
// RL4 - Exception push places status low byte in the upper byte position.
// RL5 - Stack limit register is not reset and holds an undefined value.
// RL6 - Limit bit zero always reads and acts as zero.
// RL7 - Every stack pointer based effective address is compared against the limit.
// RL8 - Push at pointer equal to limit is fine; the next push traps.
// RL9 - Any stack pointer address below 0x0800 raises an underflow trap.
// RL10 - Software should not read through the pointer right after writing the limit.
// RL11 - Boot secure RAM only reachable from boot flash code when enabled.
// RL12 - Segment secure RAM only reachable from secure flash code when enabled.
// RL13 - Overflow and underflow share one trap request, flagged the same cycle.
`timescale 1ns/1ps
module slc_stack_limit_checker
#(
	parameter int unsigned ADDR_W = 16 // Data address width
)
(
	input  wire logic               clk_sys_i,     // Core clock, 250 MHz
	input  wire logic               rst_b_i,       // Async reset, active low
	input  wire slc_pkg::slc_op_t   op_i,          // Stack operation this cycle
	input  wire logic [ADDR_W-1:0]  ea_i,          // Effective address from SP (SLC_OP_EA)
	input  wire logic [15:0]        pc_lo_i,       // Program counter low word
	input  wire logic [6:0]         pc_hi_i,       // Program counter upper bits
	input  wire logic [7:0]         status_low_byte, // Low status byte for exceptions
	input  wire logic               sp_wr_i,       // Software writes the stack pointer
	input  wire logic [ADDR_W-1:0]  sp_wdata_i,    // Stack pointer write data
	input  wire logic               lim_wr_i,      // Software writes the limit
	input  wire logic [ADDR_W-1:0]  lim_wdata_i,   // Limit write data
	input  wire logic               bsr_en_i,      // Boot secure RAM enable
	input  wire logic               ssr_en_i,      // Segment secure RAM enable
	input  wire logic               in_bsr_i,      // Access targets boot secure RAM
	input  wire logic               in_ssr_i,      // Access targets segment secure RAM
	input  wire logic               exec_boot_i,   // Executing from boot flash
	input  wire logic               exec_sec_i,    // Executing from secure flash
	output logic [ADDR_W-1:0]       sw_stack_pointer, // Current stack pointer
	output logic [ADDR_W-1:0]       stack_limit_reg,  // Limit read-back
	output logic [ADDR_W-1:0]       mem_addr_o,    // Stack access address
	output logic [15:0]             mem_wdata_o,   // Word pushed to stack
	output logic                    mem_we_o,      // Stack write strobe
	output logic                    mem_re_o,      // Stack read strobe
	output logic                    stack_trap_o,  // Stack error trap request
	output logic                    ram_block_o    // Secure RAM access refused
);
	// Pointer arithmetic and the floor compare assume a data-wide address
	if (ADDR_W != slc_pkg::DATA_W)
	begin : g_bad_width
		$error("slc: ADDR_W must equal the data width");
	end

	// Compare an address against the limit and the fixed floor
	function automatic logic bad_addr(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] lim);
		bad_addr = (a > lim) || (a < slc_pkg::STACK_FLOOR); // RL7 RL8 RL9
	endfunction

	logic [ADDR_W-1:0] lim_q;
	logic [ADDR_W-1:0] next_sp;
	logic [ADDR_W-1:0] next_addr;
	logic [15:0]       next_wdata;
	logic              next_we;
	logic              next_re;
	logic              next_trap;
	logic              next_block;
	logic              guard_block;

	slc_ram_guard u_guard
	(
		.bsr_en_i    (bsr_en_i),
		.ssr_en_i    (ssr_en_i),
		.in_bsr_i    (in_bsr_i),
		.in_ssr_i    (in_ssr_i),
		.exec_boot_i (exec_boot_i),
		.exec_sec_i  (exec_sec_i),
		.blocked_o   (guard_block)
	);

	// Limit has no reset on purpose; its value after power-up is undefined
	always_ff @(posedge clk_sys_i)
	begin
		if (lim_wr_i)
			lim_q <= {lim_wdata_i[ADDR_W-1:1], 1'b0}; // RL5 RL6
	end

	// Next pointer, access and trap from this cycle's operation
	always_comb
	begin
		next_sp    = sw_stack_pointer;
		next_addr  = mem_addr_o;
		next_wdata = mem_wdata_o;
		next_we    = 1'b0;
		next_re    = 1'b0;
		next_trap  = 1'b0;
		next_block = guard_block;
		unique case (op_i)
			slc_pkg::SLC_OP_NONE:
			begin
				next_trap = 1'b0;
			end
			slc_pkg::SLC_OP_PUSH, slc_pkg::SLC_OP_CALL, slc_pkg::SLC_OP_EXC:
			begin
				// Write at SP, then step up
				next_addr = sw_stack_pointer; // RL1 RL2
				next_we   = 1'b1;
				next_sp   = sw_stack_pointer + slc_pkg::WORD_STEP; // RL2
				next_trap = bad_addr(sw_stack_pointer, lim_q); // RL8 RL13
				if (op_i == slc_pkg::SLC_OP_CALL)
					next_wdata = {1'b0, pc_lo_i[slc_pkg::PC_MSB-1:0]}; // RL3
				else if (op_i == slc_pkg::SLC_OP_EXC)
					next_wdata = {status_low_byte, 1'b0, pc_hi_i}; // RL4
				else
					next_wdata = pc_lo_i;
			end
			slc_pkg::SLC_OP_POP:
			begin
				// Step down first, then read
				next_sp   = sw_stack_pointer - slc_pkg::WORD_STEP; // RL2
				next_addr = next_sp;
				next_re   = 1'b1;
				next_trap = bad_addr(next_sp, lim_q); // RL9 RL13
			end
			slc_pkg::SLC_OP_EA:
			begin
				next_addr = ea_i;
				next_re   = 1'b1;
				next_trap = bad_addr(ea_i, lim_q); // RL7 RL13
			end
			default:
			begin
				next_trap = 1'b0;
			end
		endcase
		if (sp_wr_i)
			next_sp = {sp_wdata_i[ADDR_W-1:1], 1'b0};
		// Suppress blocked or trapped accesses
		if (guard_block || next_trap) // RL11 RL12
		begin
			next_we = 1'b0;
			next_re = 1'b0;
		end
	end

	// Register state and outputs
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sw_stack_pointer <= slc_pkg::SP_RESET;
			mem_addr_o       <= '0;
			mem_wdata_o      <= 16'h0000;
			mem_we_o         <= 1'b0;
			mem_re_o         <= 1'b0;
			stack_trap_o     <= 1'b0;
			ram_block_o      <= 1'b0;
		end
		else
		begin
			sw_stack_pointer <= next_sp;
			mem_addr_o       <= next_addr;
			mem_wdata_o      <= next_wdata;
			mem_we_o         <= next_we;
			mem_re_o         <= next_re;
			stack_trap_o     <= next_trap; // RL13
			ram_block_o      <= next_block;
		end
	end

	// Read-back; limit is unreset so it shows X until first written
	always_ff @(posedge clk_sys_i)
	begin
		stack_limit_reg <= lim_q; // RL6
	end
endmodule // slc_stack_limit_checker

// *** pkg/slc_pkg.sv ***
// Package: constants and types for the stack limit checker
package slc_pkg;
	localparam int unsigned DATA_W = 16;
	// Lowest legal stack address; below it lies the register file space
	localparam logic [15:0] STACK_FLOOR = 16'h0800;
	// Bit of the limit that is forced low for word alignment
	localparam int unsigned LIMIT_ALIGN_BIT = 0;
	// Reset value of the stack pointer (points at the floor)
	localparam logic [15:0] SP_RESET = 16'h0800;
	// Top bit of a stacked program counter word
	localparam int unsigned PC_MSB = 15;
	// Word step of the stack pointer
	localparam logic [15:0] WORD_STEP = 16'h0002;

	// Stack operation requested by the core
	typedef enum logic [2:0] {
		SLC_OP_NONE  = 3'b000,
		SLC_OP_PUSH  = 3'b001,
		SLC_OP_POP   = 3'b010,
		SLC_OP_CALL  = 3'b011,
		SLC_OP_EXC   = 3'b100,
		SLC_OP_EA    = 3'b101
	} slc_op_t;
endpackage

// *** test/slc_core_model.sv ***
// Exception side of the core: takes stack error trap requests
`timescale 1ns/1ps
module slc_core_model
(
	input  wire logic clk_sys_i,    // Core clock
	input  wire logic rst_b_i,      // Async reset, active low
	input  wire logic stack_trap_o, // Trap request pulse
	output int        traps         // Requests taken
);
	// One count per cycle, as each request is a single-cycle pulse
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
		if (!rst_b_i)
			traps <= 0;
		else
			traps <= traps + int'(stack_trap_o);
endmodule // slc_core_model

// *** test/slc_sva.sv ***
// Concurrent checks on the stack limit checker ports
`timescale 1ns/1ps
module slc_sva
#(
	parameter int unsigned ADDR_W = 16 // Data address width
)
(
	input wire logic clk_sys_i, rst_b_i, sp_wr_i, bsr_en_i, in_bsr_i, exec_boot_i, // Controls
	input wire slc_pkg::slc_op_t op_i, // Stack operation
	input wire logic [ADDR_W-1:0] ea_i, sw_stack_pointer, mem_addr_o, // Addresses
	input wire logic [15:0] pc_lo_i, mem_wdata_o, // Data words
	input wire logic [6:0] pc_hi_i, // PC upper bits
	input wire logic [7:0] status_low_byte, // Status low byte
	input wire logic mem_we_o, mem_re_o, stack_trap_o, ram_block_o // Results
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	// A push is only counted when software does not overwrite the pointer
	sequence s_push; op_i == slc_pkg::SLC_OP_PUSH && !sp_wr_i; endsequence
	property p_push; s_push |=> mem_addr_o == $past(sw_stack_pointer)
		&& sw_stack_pointer == $past(sw_stack_pointer) + 16'h0002; endproperty
	a_push: assert property (p_push) else $error("push address or step wrong");
	property p_pop; op_i == slc_pkg::SLC_OP_POP && !sp_wr_i |=> mem_addr_o == sw_stack_pointer
		&& sw_stack_pointer == $past(sw_stack_pointer) - 16'h0002; endproperty
	a_pop: assert property (p_pop) else $error("pop not pre-decremented");
	property p_call; op_i == slc_pkg::SLC_OP_CALL |=> mem_wdata_o == {1'b0, $past(pc_lo_i[14:0])}; endproperty
	a_call: assert property (p_call) else $error("call word top bit not clear");
	property p_exc; op_i == slc_pkg::SLC_OP_EXC
		|=> mem_wdata_o == {$past(status_low_byte), 1'b0, $past(pc_hi_i)}; endproperty
	a_exc: assert property (p_exc) else $error("exception word layout wrong");
	property p_under; s_push and sw_stack_pointer < 16'h0800 |=> stack_trap_o; endproperty
	a_under: assert property (p_under) else $error("push below floor not trapped");
	property p_ea_low; op_i == slc_pkg::SLC_OP_EA && ea_i < 16'h0800 |=> stack_trap_o; endproperty
	a_ea_low: assert property (p_ea_low) else $error("low address not trapped");
	property p_refuse; stack_trap_o |-> !mem_we_o && !mem_re_o; endproperty
	a_refuse: assert property (p_refuse) else $error("trapped access not suppressed");
	property p_bsr; bsr_en_i && in_bsr_i && !exec_boot_i |=> ram_block_o; endproperty
	a_bsr: assert property (p_bsr) else $error("boot secure ram not blocked");
endmodule // slc_sva

bind slc_stack_limit_checker slc_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// *** test/tb_top.sv ***
// Self-checking bench for the stack limit checker
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_i = 0, rst_b_i = 0, sp_wr_i = 0, lim_wr_i = 0, mem_we_o, mem_re_o, stack_trap_o;
	logic ram_block_o;
	slc_pkg::slc_op_t op_i = slc_pkg::SLC_OP_NONE;
	logic [15:0] ea_i = 16'h0, pc_lo_i = 16'h0, sp_wdata_i = 16'h0, lim_wdata_i = 16'h0, sp, lim;
	logic [15:0] mem_addr_o, mem_wdata_o, lx, a;
	logic [6:0] pc_hi_i = 7'h0;
	logic [7:0] status_low_byte = 8'h0;
	logic [5:0] g = 6'h0; // Secure gate inputs
	int mismatches = 0, checks_done = 0, traps, n = 0;
	slc_stack_limit_checker i_dut (.clk_sys_i, .rst_b_i, .op_i, .ea_i, .pc_lo_i, .pc_hi_i,
		.status_low_byte, .sp_wr_i, .sp_wdata_i, .lim_wr_i, .lim_wdata_i, .bsr_en_i(g[0]),
		.ssr_en_i(g[1]), .in_bsr_i(g[2]), .in_ssr_i(g[3]), .exec_boot_i(g[4]),
		.exec_sec_i(g[5]), .sw_stack_pointer(sp), .stack_limit_reg(lim), .mem_addr_o,
		.mem_wdata_o, .mem_we_o, .mem_re_o, .stack_trap_o, .ram_block_o);
	slc_core_model i_core (.clk_sys_i, .rst_b_i, .stack_trap_o, .traps);
	// Expected trap and gate results
	function automatic logic trap_exp(input logic [15:0] v);
		return v > lx || v < 16'h0800;
	endfunction
	function automatic logic blk(input logic [5:0] v);
		return (v[0] & v[2] & !v[4]) | (v[1] & v[3] & !v[5]);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One operation, taken at the second edge, results sampled just after
	task automatic go(input slc_pkg::slc_op_t o, input logic [15:0] v);
		n += int'(trap_exp(v));
		@(posedge clk_sys_i) op_i <= o;
		@(posedge clk_sys_i) op_i <= slc_pkg::SLC_OP_NONE;
		#1 chk(mem_addr_o, v);
		chk(16'(stack_trap_o), 16'(trap_exp(v)));
		chk(16'(mem_we_o | mem_re_o), 16'(!trap_exp(v)));
	endtask
	// Two spare cycles after a write keep pointer reads clear of a fresh limit
	task automatic wreg(input logic is_lim, input logic [15:0] v);
		sp_wdata_i <= v;
		lim_wdata_i <= v;
		@(posedge clk_sys_i) {sp_wr_i, lim_wr_i} <= {!is_lim, is_lim};
		@(posedge clk_sys_i) {sp_wr_i, lim_wr_i} <= 2'b00;
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask
	initial forever #2 clk_sys_i = ~clk_sys_i;
	initial
	begin
		#40000 mismatches++;
		give_verdict();
	end
	// Main sequence
	initial
	begin
		void'($urandom(32'h11b5));
		repeat (12) @(posedge clk_sys_i);
		rst_b_i <= 1;
		#1 lx = 16'h0801 + 16'(2 * $urandom_range(2, 8));
		wreg(1, lx);
		chk(lim, lx & 16'hfffe);
		lx = lx & 16'hfffe;
		for (a = 16'h0800; a <= lx + 16'h2; a += 16'h2)
		begin
			pc_lo_i <= 16'($urandom);
			go(slc_pkg::SLC_OP_PUSH, a);
			chk(mem_wdata_o, pc_lo_i);
		end
		chk(sp, lx + 16'h4);
		go(slc_pkg::SLC_OP_POP, lx + 16'h2);
		go(slc_pkg::SLC_OP_POP, lx);
		wreg(0, 16'h07fe);
		go(slc_pkg::SLC_OP_PUSH, 16'h07fe);
		for (int i = 0; i < 24; i++)
		begin
			// Corner addresses first, then random ones; expectation uses the driven value
			a = (i == 0) ? 16'h07fe : (i == 1) ? 16'h0800 : (i == 2) ? lx : (i == 3) ? lx + 16'h2 : 16'($urandom);
			ea_i <= a;
			go(slc_pkg::SLC_OP_EA, a);
		end
		wreg(0, 16'h0800);
		repeat (4)
		begin
			{pc_lo_i, pc_hi_i, status_low_byte} <= 31'($urandom);
			go(slc_pkg::SLC_OP_CALL, 16'h0800);
			chk(mem_wdata_o, {1'b0, pc_lo_i[14:0]});
			wreg(0, 16'h0800);
			go(slc_pkg::SLC_OP_EXC, 16'h0800);
			chk(mem_wdata_o, {status_low_byte, 1'b0, pc_hi_i});
			wreg(0, 16'h0800);
		end
		for (int i = 0; i < 64; i++)
		begin
			g <= 6'(i);
			@(posedge clk_sys_i) #1 chk(16'(ram_block_o), 16'(blk(g)));
		end
		chk(16'(traps), 16'(n));
		give_verdict();
	end
endmodule // tb_top
